//--- ibc_pkg.sv
// constants and carrier types shared by the in-band loop code block
package ibc_pkg;

   // ---------------------------------------------------------------
   // register offsets on the parallel control port
   // ---------------------------------------------------------------
   localparam logic [7:0] IBC_ADDR_CODE_CTRL = 8'h12;
   localparam logic [7:0] IBC_ADDR_TX_PAT = 8'h13;
   localparam logic [7:0] IBC_ADDR_UP_PAT = 8'h14;
   localparam logic [7:0] IBC_ADDR_DOWN_PAT = 8'h15;
   localparam logic [7:0] IBC_ADDR_STATUS_ONE = 8'h20;
   localparam logic [7:0] IBC_ADDR_CTRL_THREE = 8'h30;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int IBC_TX_LEN_LSB = 6;     // code control bits 7..6
   localparam int IBC_UP_LEN_LSB = 3;     // code control bits 5..3
   localparam int IBC_DOWN_LEN_LSB = 0;   // code control bits 2..0
   localparam int IBC_LOOP_TX_EN_BIT = 1; // control three bit 1
   localparam int IBC_NO_FBIT_BIT = 0;    // control three bit 0
   localparam int IBC_UP_DET_BIT = 7;     // status one bit 7
   localparam int IBC_DOWN_DET_BIT = 6;   // status one bit 6

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] IBC_RST_CODE_CTRL = 8'h00;
   localparam logic [7:0] IBC_RST_PAT = 8'h00;
   localparam logic [7:0] IBC_RST_CTRL_THREE = 8'h00;
   localparam logic [7:0] IBC_RST_FRAME_CNT = 8'hc0;

   // ---------------------------------------------------------------
   // length decoding and timing
   // ---------------------------------------------------------------
   localparam logic [3:0] IBC_TX_LEN_BASE = 4'h5;  // 00 selects 5 bits
   localparam logic [3:0] IBC_RX_LEN_BASE = 4'h1;  // 000 selects 1 bit
   localparam logic [7:0] IBC_FRAME_BITS = 8'hc1;  // 193 bits a frame
   localparam longint IBC_CLK_HZ = 125000000;
   localparam longint IBC_WINDOW_MS = 48;
   localparam longint IBC_WINDOW_CYCLES = IBC_WINDOW_MS * IBC_CLK_HZ / 1000;
   localparam int IBC_CNT_W = 24;         // window and bit counters
   localparam int IBC_BAD_SHIFT = 3;      // tolerate one misfit bit in 8
   localparam int IBC_FIFO_DEPTH = 8;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       wr;    // one-cycle write strobe
      logic       rd;    // one-cycle read strobe
      logic [7:0] addr;
      logic [7:0] wdata;
   } ibc_reg_req_t;

   typedef struct packed {
      logic bitEn;       // one-cycle enable per transmit line bit
      logic frameSync;   // marks the framing bit slot
      logic data;        // line data from the formatter
      logic fbit;        // framing bit value for this slot
   } ibc_tx_line_t;

endpackage

//--- ibc_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module ibc_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // all fifo state in one record
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [CW-1:0] count;
   } ibc_fifo_state_t;

   ibc_fifo_state_t state_q;  // registered state
   ibc_fifo_state_t state_d;  // next state

   logic push;  // accepted write
   logic pop;   // accepted read

   // ---------------------------------------------------------------
   // handshakes: honest full and empty from the count
   // ---------------------------------------------------------------
   assign inReady = (state_q.count != CW'(DEPTH));
   assign outValid = (state_q.count != '0);
   assign outData = state_q.mem[state_q.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // pointer wrap helper, depth need not be a power of two
   function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
      nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (push) begin
         state_d.mem[state_q.wrPtr] = inData;
         state_d.wrPtr = nextPtr(state_q.wrPtr);
      end
      if (pop) begin
         state_d.rdPtr = nextPtr(state_q.rdPtr);
      end
      // simultaneous push and pop leaves the count alone
      if (push && !pop) begin
         state_d.count = state_q.count + 1'b1;
      end else if (pop && !push) begin
         state_d.count = state_q.count - 1'b1;
      end
   end

   // reset clears the storage as well as the pointers and count
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q.mem <= '0;
         state_q.wrPtr <= '0;
         state_q.rdPtr <= '0;
         state_q.count <= '0;
      end else begin
         state_q <= state_d;
      end
   end

endmodule

//--- ibc_loop_code.sv
// in-band loop code generator and dual loop-up / loop-down detector
`timescale 1ns/10ps
module ibc_loop_code #(
   parameter longint WINDOW_CYCLES = ibc_pkg::IBC_WINDOW_CYCLES,
   parameter int FIFO_DEPTH = ibc_pkg::IBC_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire ibc_pkg::ibc_reg_req_t regReq,
   output logic [7:0] regRdData,
   input wire ibc_pkg::ibc_tx_line_t txLine,
   output logic txDataOut,
   input wire logic rxValid,
   input wire logic rxData,
   output logic rxReady,
   output logic loopUpDetected,
   output logic loopDownDetected
);
   import ibc_pkg::*;

   // ---------------------------------------------------------------
   // local constants and state record
   // ---------------------------------------------------------------
   localparam logic [IBC_CNT_W-1:0] WIN_LAST = IBC_CNT_W'(WINDOW_CYCLES - 1);

   typedef struct packed {
      logic [7:0] codeCtrl;   // inband_code_control
      logic [7:0] txPat;      // transmit_code_pattern
      logic [7:0] upPat;      // loop_up_pattern_def
      logic [7:0] downPat;    // loop_down_pattern_def
      logic [7:0] ctrlThree;  // common_control_three
      logic [7:0] rdData;     // read answer register
      logic [2:0] txPhase;    // index of next pattern bit
      logic [7:0] frameCnt;   // position in the 193-bit frame
      logic txData;           // bit on the line
      logic [7:0] hist;       // last received bits, bit 0 newest
      logic [3:0] histFill;   // how many history bits are valid
      logic [IBC_CNT_W-1:0] winCnt;            // window countdown
      logic [IBC_CNT_W-1:0] bitCnt;            // bits seen this window
      logic [1:0][IBC_CNT_W-1:0] badCnt;       // misfits per detector
      logic [1:0] detected;   // 1 = loop-up, 0 = loop-down
      logic [1:0] passed;     // previous window met the misfit limit
   } ibc_state_t;

   ibc_state_t state_q;  // registered state
   ibc_state_t state_d;  // next state

   logic fifoValid;      // a received bit waits in the fifo
   logic fifoBit;        // the oldest received bit
   logic fifoPop;        // the detectors take a bit this cycle
   logic winEnd;         // evaluation cycle at the end of a window
   logic [3:0] txLen;    // decoded transmit length
   logic [1:0][3:0] rxLen;   // decoded receive lengths
   logic [1:0][7:0] rxPat;   // receive patterns per detector

   // ---------------------------------------------------------------
   // receive bit buffer
   // ---------------------------------------------------------------
   // the detectors stall for the evaluation cycle, so the framer
   // must honour rxReady or lose bits
   ibc_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inValid(rxValid),
      .inData(rxData),
      .inReady(rxReady),
      .outValid(fifoValid),
      .outData(fifoBit),
      .outReady(!winEnd)
   );

   assign winEnd = (state_q.winCnt == '0);
   assign fifoPop = fifoValid && !winEnd;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // transmit length: 00..11 map to 5..8 bits
   function automatic logic [3:0] decodeTxLen(input logic [1:0] f);
      decodeTxLen = IBC_TX_LEN_BASE + {2'b00, f};
   endfunction

   // receive length: field value plus one
   function automatic logic [3:0] decodeRxLen(input logic [2:0] f);
      decodeRxLen = IBC_RX_LEN_BASE + {1'b0, f};
   endfunction

   // true when the newest len history bits are a phase of the
   // pattern; only bits 7 down to 8-len of the pattern take part
   function automatic logic rotMatch(input logic [7:0] h,
                                     input logic [7:0] p,
                                     input logic [3:0] len);
      logic ok;
      logic [4:0] j;
      rotMatch = 1'b0;
      for (int r = 0; r < 8; r++) begin
         ok = (r < len);
         for (int i = 0; i < 8; i++) begin
            if (i < len) begin
               // bit i cycles old sits r-i places along the code
               j = 5'(r) + {1'b0, len} - 5'(i);
               if (j >= {1'b0, len}) begin
                  j = j - {1'b0, len};
               end
               if (h[i] != p[7 - j[2:0]]) begin
                  ok = 1'b0;
               end
            end
         end
         if (ok) begin
            rotMatch = 1'b1;
         end
      end
   endfunction

   // address decode for the read mux only; writes decode separately
   function automatic logic [7:0] readReg(input ibc_state_t s,
                                          input logic [7:0] a);
      case (a)
         IBC_ADDR_CODE_CTRL: readReg = s.codeCtrl;
         IBC_ADDR_TX_PAT: readReg = s.txPat;
         IBC_ADDR_UP_PAT: readReg = s.upPat;
         IBC_ADDR_DOWN_PAT: readReg = s.downPat;
         IBC_ADDR_CTRL_THREE: readReg = s.ctrlThree;
         IBC_ADDR_STATUS_ONE: begin
            readReg = '0;
            readReg[IBC_UP_DET_BIT] = s.detected[1];
            readReg[IBC_DOWN_DET_BIT] = s.detected[0];
         end
         default: readReg = '0;  // unmapped reads as zero
      endcase
   endfunction

   // ---------------------------------------------------------------
   // field decode
   // ---------------------------------------------------------------
   // control register layout: tx 7:6, up 5:3, down 2:0
   assign txLen = decodeTxLen(
      state_q.codeCtrl[IBC_TX_LEN_LSB +: 2]);
   assign rxLen[1] = decodeRxLen(
      state_q.codeCtrl[IBC_UP_LEN_LSB +: 3]);
   assign rxLen[0] = decodeRxLen(
      state_q.codeCtrl[IBC_DOWN_LEN_LSB +: 3]);
   assign rxPat[1] = state_q.upPat;
   assign rxPat[0] = state_q.downPat;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic isFslot;          // this line bit is the framing slot
      logic loopOn;           // loop code transmit enabled
      logic [7:0] newHist;    // history with the popped bit
      logic [3:0] newFill;    // fill count with the popped bit
      isFslot = 1'b0;
      loopOn = state_q.ctrlThree[IBC_LOOP_TX_EN_BIT];
      newHist = {state_q.hist[6:0], fifoBit};
      newFill = (state_q.histFill == 4'h8) ? 4'h8
                                           : state_q.histFill + 4'h1;
      state_d = state_q;

      // register writes; status one is read only
      if (regReq.wr) begin
         case (regReq.addr)
            IBC_ADDR_CODE_CTRL: state_d.codeCtrl = regReq.wdata;
            IBC_ADDR_TX_PAT: state_d.txPat = regReq.wdata;
            IBC_ADDR_UP_PAT: state_d.upPat = regReq.wdata;
            IBC_ADDR_DOWN_PAT: state_d.downPat = regReq.wdata;
            IBC_ADDR_CTRL_THREE: state_d.ctrlThree = regReq.wdata;
            default: ;  // writes elsewhere are dropped
         endcase
      end
      // read answer captured on the strobe, held until the next one
      if (regReq.rd) begin
         state_d.rdData = readReg(state_q, regReq.addr);
      end

      // transmit side, one step per line bit
      if (txLine.bitEn) begin
         // framing slot from the sync mark or the free-running count
         isFslot = txLine.frameSync ||
                   (state_q.frameCnt == IBC_FRAME_BITS - 8'h01);
         state_d.frameCnt = isFslot ? 8'h00 : state_q.frameCnt + 8'h01;
         if (loopOn) begin
            if (isFslot && !state_q.ctrlThree[IBC_NO_FBIT_BIT]) begin
               // framing bit overwrites, code keeps running beneath
               state_d.txData = txLine.fbit;
            end else begin
               // msb first, bits past the length never reached
               state_d.txData = state_q.txPat[3'h7 - state_q.txPhase];
            end
            // wrap after the last bit of the selected length
            if ({1'b0, state_q.txPhase} == txLen - 4'h1) begin
               state_d.txPhase = 3'h0;
            end else begin
               state_d.txPhase = state_q.txPhase + 3'h1;
            end
         end else begin
            // disabled: line data passes untouched, code restarts
            state_d.txData = txLine.data;
            state_d.txPhase = 3'h0;
         end
      end

      // receive side: one popped bit updates both detectors
      if (fifoPop) begin
         state_d.hist = newHist;
         state_d.histFill = newFill;
         state_d.bitCnt = state_q.bitCnt + 1'b1;
         for (int k = 0; k < 2; k++) begin
            // a framing bit or line error spoils at most len successive matches only
            if (newFill < rxLen[k] ||
                !rotMatch(newHist, rxPat[k], rxLen[k])) begin
               state_d.badCnt[k] = state_q.badCnt[k] + 1'b1;
            end
         end
      end

      // window timing and the verdict
      if (winEnd) begin
         state_d.winCnt = WIN_LAST;
         state_d.bitCnt = '0;
         for (int k = 0; k < 2; k++) begin
            // present only if misfits stay at or under one in eight;
            // a failed window drops the status and starts over
            state_d.passed[k] = (state_q.bitCnt != '0) &&
               (state_q.badCnt[k] <=
                (state_q.bitCnt >> IBC_BAD_SHIFT));
            // two passing windows in a row: a code that starts late
            // in a window cannot be declared before a full window
            state_d.detected[k] = state_d.passed[k] &&
               state_q.passed[k];
            state_d.badCnt[k] = '0;
         end
      end else begin
         state_d.winCnt = state_q.winCnt - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q.codeCtrl <= IBC_RST_CODE_CTRL;
         state_q.txPat <= IBC_RST_PAT;
         state_q.upPat <= IBC_RST_PAT;
         state_q.downPat <= IBC_RST_PAT;
         state_q.ctrlThree <= IBC_RST_CTRL_THREE;
         state_q.rdData <= 8'h00;
         state_q.txPhase <= 3'h0;
         state_q.frameCnt <= IBC_RST_FRAME_CNT;
         state_q.txData <= 1'b0;
         state_q.hist <= 8'h00;
         state_q.histFill <= 4'h0;
         state_q.winCnt <= WIN_LAST;
         state_q.bitCnt <= '0;
         state_q.badCnt <= '0;
         state_q.detected <= 2'b00;
         state_q.passed <= 2'b00;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign regRdData = state_q.rdData;
   assign txDataOut = state_q.txData;
   assign loopUpDetected = state_q.detected[1];
   assign loopDownDetected = state_q.detected[0];

endmodule

//--- ibc_loop_code_assertions.sv
// port checker for the in-band loop code block
`timescale 1ns/10ps
module ibc_loop_code_assertions #(
   parameter longint WINDOW_CYCLES = 200
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire ibc_pkg::ibc_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   input wire ibc_pkg::ibc_tx_line_t txLine,
   input wire logic txDataOut,
   input wire logic rxValid,
   input wire logic rxData,
   input wire logic rxReady,
   input wire logic loopUpDetected,
   input wire logic loopDownDetected
);
   import ibc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   logic [7:0] ctrlThree_q; // shadow of control three, kept from writes
   logic rdMapped;          // read aimed at a mapped place

   assign rdMapped = regReq.addr inside {IBC_ADDR_CODE_CTRL, IBC_ADDR_TX_PAT,
      IBC_ADDR_UP_PAT, IBC_ADDR_DOWN_PAT, IBC_ADDR_STATUS_ONE,
      IBC_ADDR_CTRL_THREE};

   // the shadow follows writes on the same edge as the block does
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrlThree_q <= 8'h00;
      end else if (regReq.wr && regReq.addr == IBC_ADDR_CTRL_THREE) begin
         ctrlThree_q <= regReq.wdata;
      end
   end

   chk_reset_clears: assert property (!rst_n |=> regRdData == 8'h00
      && !txDataOut && !loopUpDetected && !loopDownDetected && rxReady)
      else $error("outputs not cleared by reset");
   // status may be sampled either side of a window end
   chk_status_read: assert property (disable iff (!rst_n)
      regReq.rd && regReq.addr == IBC_ADDR_STATUS_ONE |=>
      regRdData[5:0] == 6'h00 && (regRdData[7:6] == {$past(loopUpDetected),
      $past(loopDownDetected)} || regRdData[7:6] ==
      {loopUpDetected, loopDownDetected}))
      else $error("status read disagrees with detector outputs");
   chk_unmapped_zero: assert property (disable iff (!rst_n)
      regReq.rd && !rdMapped |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   chk_read_holds: assert property (disable iff (!rst_n)
      !regReq.rd |=> $stable(regRdData))
      else $error("read data moved without a read");
   chk_write_readback: assert property (disable iff (!rst_n)
      regReq.wr && regReq.addr == IBC_ADDR_CODE_CTRL ##1 regReq.rd
      && !regReq.wr && regReq.addr == IBC_ADDR_CODE_CTRL
      |=> regRdData == $past(regReq.wdata, 2))
      else $error("code control readback wrong");
   chk_tx_holds: assert property (disable iff (!rst_n)
      !txLine.bitEn |=> $stable(txDataOut))
      else $error("line bit moved without a bit enable");
   chk_tx_passthru: assert property (disable iff (!rst_n)
      txLine.bitEn && !ctrlThree_q[IBC_LOOP_TX_EN_BIT] && !txLine.frameSync
      |=> txDataOut == $past(txLine.data))
      else $error("line data not passed while code sending is off");
   chk_fbit_slot: assert property (disable iff (!rst_n)
      txLine.bitEn && txLine.frameSync && ctrlThree_q[IBC_LOOP_TX_EN_BIT]
      && !ctrlThree_q[IBC_NO_FBIT_BIT] |=> txDataOut == $past(txLine.fbit))
      else $error("framing bit not sent in its slot");
endmodule

//--- ibc_line_partner.sv
// far-end line model: streams a repeating loop code into the receiver
`timescale 1ns/10ps
module ibc_line_partner (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sendOn,        // stream the code while high
   input wire logic [7:0] sendPat, // code, first bit in bit 7
   input wire logic [3:0] sendLen, // code length, 1 to 8
   input wire logic framed,        // framing bit every 193 bits
   input wire logic [7:0] errGap,  // invert one bit in this many, 0 none
   input wire logic rxReady,
   output logic rxValid,
   output logic rxData
);
   logic [3:0] phase_q; // position in the code
   logic [7:0] frame_q; // position in the frame
   logic [7:0] err_q;   // counts up to the next inverted bit
   logic fbit_q;        // alternating framing bit
   logic last_q;        // last bit handed over
   logic codeBit;

   // code bit, framing slot over it, then the deliberate error
   always_comb begin
      codeBit = sendPat[3'd7 - phase_q[2:0]];
      if (framed && frame_q == 8'd0) begin
         codeBit = fbit_q;
      end
      if (errGap != 8'd0 && err_q == errGap - 8'd1) begin
         codeBit = ~codeBit;
      end
      // an idle line never repeats the last bit, so stale data cannot match
      rxData = rxValid ? codeBit : ~last_q;
   end

   // a bit stays offered until the receiver takes it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_q <= 4'd0;
         frame_q <= 8'd0;
         err_q <= 8'd0;
         fbit_q <= 1'b0;
         last_q <= 1'b0;
         rxValid <= 1'b0;
      end else begin
         if (rxValid && rxReady) begin
            phase_q <= (phase_q + 4'd1 >= sendLen) ? 4'd0 : phase_q + 4'd1;
            frame_q <= (frame_q == 8'd192) ? 8'd0 : frame_q + 8'd1;
            err_q <= (err_q + 8'd1 >= errGap) ? 8'd0 : err_q + 8'd1;
            fbit_q <= (frame_q == 8'd0) ? ~fbit_q : fbit_q;
            last_q <= rxData;
         end
         if (!rxValid || rxReady) begin
            rxValid <= sendOn;
         end
      end
   end
endmodule

//--- ibc_loop_code_tb.sv
// self-checking bench for the in-band loop code block
`timescale 1ns/10ps
module ibc_loop_code_tb;
   import ibc_pkg::*;
   localparam longint WIN = 200; // shortened detection window
   localparam logic [7:0] REGS [5] = '{IBC_ADDR_CODE_CTRL, IBC_ADDR_TX_PAT,
      IBC_ADDR_UP_PAT, IBC_ADDR_DOWN_PAT, 8'h40};
   logic clk_sys, rst_n, txDataOut, rxValid, rxData, rxReady;
   logic loopUpDetected, loopDownDetected, sendOn, framed, rdWas, txWas;
   ibc_reg_req_t regReq;
   ibc_tx_line_t txLine;
   logic [7:0] regRdData, sendPat, errGap;
   logic [3:0] sendLen;
   logic [31:0] seed;
   logic [7:0] expRd[$]; // read answers still to come
   logic expTx[$];       // line bits still to come
   int failures, checks;

   ibc_loop_code #(.WINDOW_CYCLES(WIN)) uut (.clk_sys(clk_sys),
      .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
      .txLine(txLine), .txDataOut(txDataOut), .rxValid(rxValid),
      .rxData(rxData), .rxReady(rxReady), .loopUpDetected(loopUpDetected),
      .loopDownDetected(loopDownDetected));
   ibc_line_partner far (.clk_sys(clk_sys), .rst_n(rst_n), .sendOn(sendOn),
      .sendPat(sendPat), .sendLen(sendLen), .framed(framed),
      .errGap(errGap), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic compare(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // each of the four bus tasks below drives both request buses once per edge
   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regReq <= '{1'b1, 1'b0, a, d};
      txLine <= '0;
   endtask

   task automatic regRead(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      regReq <= '{1'b0, 1'b1, a, 8'h00};
      txLine <= '0;
      expRd.push_back(exp);
   endtask

   task automatic txBit(input logic fs, input logic d, input logic fb,
         input logic exp);
      @(posedge clk_sys);
      regReq <= '0;
      txLine <= '{1'b1, fs, d, fb};
      expTx.push_back(exp);
   endtask

   task automatic idle;
      @(posedge clk_sys);
      regReq <= '0;
      txLine <= '0;
   endtask

   // bounded wait for the detector outputs to reach a state
   task automatic waitDet(input logic [1:0] want, output int n);
      n = 0;
      while ({loopUpDetected, loopDownDetected} !== want && n < 6 * WIN) begin
         @(posedge clk_sys);
         n++;
      end
      compare("detector outputs", {6'h00, want},
         {6'h00, loopUpDetected, loopDownDetected});
      if (n >= 6 * WIN) begin
         complete_run();
      end
   endtask

   // results land one edge after the request that caused them
   always @(posedge clk_sys) begin
      if (rdWas) begin
         compare("regRdData", expRd.pop_front(), regRdData);
      end
      if (txWas) begin
         compare("txDataOut", {7'h00, expTx.pop_front()}, {7'h00, txDataOut});
      end
      rdWas = regReq.rd;
      txWas = txLine.bitEn;
   end

   initial begin
      logic [7:0] pat;
      int n;
      rst_n = 1'b0;
      regReq = '0;
      txLine = '0;
      {sendOn, framed, sendPat, errGap, sendLen} = '0;
      {rdWas, txWas, failures, checks} = '0;
      seed = 32'hd3d2;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (REGS[i]) regRead(REGS[i], 8'h00);
      regRead(IBC_ADDR_CTRL_THREE, 8'h00);
      regWrite(IBC_ADDR_STATUS_ONE, 8'hff);
      regRead(IBC_ADDR_STATUS_ONE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         regWrite(REGS[i], seed[7:0]);
         regRead(REGS[i], seed[7:0]);
      end
      // every transmit length, code sent msb first, then switched off
      for (int lc = 0; lc < 4; lc++) begin
         seed = lfsr(seed);
         pat = seed[15:8];
         regWrite(IBC_ADDR_CODE_CTRL, 8'(lc << 6));
         regWrite(IBC_ADDR_TX_PAT, pat);
         regWrite(IBC_ADDR_CTRL_THREE, 8'h03);
         for (int k = 0; k < 2 * (5 + lc) + 1; k++) begin
            seed = lfsr(seed);
            txBit(1'b0, seed[0], seed[1], pat[7 - k % (5 + lc)]);
         end
         regWrite(IBC_ADDR_CTRL_THREE, 8'h01);
         for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            txBit(1'b0, seed[0], seed[1], seed[0]);
         end
      end
      // framing slot overwrites the code, counted on through 193 bits
      regWrite(IBC_ADDR_CODE_CTRL, 8'h00);
      regWrite(IBC_ADDR_TX_PAT, 8'h80);
      regWrite(IBC_ADDR_CTRL_THREE, 8'h02);
      for (int k = 0; k < 200; k++) begin
         seed = lfsr(seed);
         txBit(k == 0, seed[0], seed[1],
            (k % 193 == 0) ? seed[1] : (k % 5 == 0));
      end
      // up code 5 bits framed with errors, then down code 3 bits, then none
      regWrite(IBC_ADDR_CTRL_THREE, 8'h00);
      regWrite(IBC_ADDR_CODE_CTRL, 8'h22);
      regWrite(IBC_ADDR_UP_PAT, 8'h80);
      regWrite(IBC_ADDR_DOWN_PAT, 8'hc0);
      idle();
      {sendPat, sendLen, framed, errGap, sendOn} <= {8'h80, 4'd5, 1'b1,
         8'd100, 1'b1};
      waitDet(2'b10, n);
      compare("detect latency", {7'h00, n >= WIN}, 8'h01);
      regRead(IBC_ADDR_STATUS_ONE, 8'h80);
      idle();
      {sendPat, sendLen, framed} <= {8'hc0, 4'd3, 1'b0};
      waitDet(2'b01, n);
      regRead(IBC_ADDR_STATUS_ONE, 8'h40);
      idle();
      sendOn <= 1'b0;
      waitDet(2'b00, n);
      idle();
      complete_run();
   end
endmodule

bind ibc_loop_code ibc_loop_code_assertions #(.WINDOW_CYCLES(WINDOW_CYCLES))
   chk (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
   .regRdData(regRdData), .txLine(txLine), .txDataOut(txDataOut),
   .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
   .loopUpDetected(loopUpDetected), .loopDownDetected(loopDownDetected));
